// ### src/power_module_command_bank.sv
// Command register bank of a digital step-down power module: status, telemetry,
// configuration, capture record, autotune and factory-restore commands.
// Assumes the serial bus engine decodes transactions into one-cycle requests on
// mclk; telemetry and capture words come from logic on the same clock.
`timescale 1ns/100ps

module power_module_command_bank
    import cmd_bank_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        req_valid,
    input  wire cmd_req_s                    req,
    output logic                             rsp_valid,
    output logic [15:0]                      rsp_data,
    output logic                             rsp_err,
    input  wire telemetry_s                  telemetry,
    input  wire logic [7:0]                  vendor_fault_set,
    input  wire logic                        fault_clear,
    input  wire logic                        capture_strobe,
    input  wire logic [8*CAPTURE_BYTES-1:0]  capture_data,
    input  wire logic                        good_threshold_raw,
    output logic                             output_good_pin,
    output logic                             autotune_start,
    output logic                             restore_done,
    output logic [RW_COUNT-1:0][15:0]        config_words
);

    logic [15:0]               rw_reg [RW_COUNT];
    logic [7:0]                comm_err;
    logic [7:0]                vendor_mon;
    logic [8*CAPTURE_BYTES-1:0] capture_rec;
    logic                      thr_meta;
    logic                      thr_sync;
    logic [4:0]                tick_cnt;
    logic                      tick;
    logic [31:0]               good_cnt;
    logic [31:0]               good_delay_us;
    logic                      hit_rw;
    logic [4:0]                hit_idx;
    logic                      is_write;
    logic                      is_send;
    logic                      do_restore;
    logic                      bad_cmd;
    logic [15:0]               next_rsp_data;
    logic                      next_rsp_err;

    // eleven-bit linear milliseconds to microseconds, negatives give zero
    function automatic logic [31:0] l11_ms_to_us(input logic [15:0] w);
        logic signed [10:0] man;
        logic signed [4:0]  expo;
        logic [47:0]        prod;
        logic [47:0]        scaled;
        man    = w[L11_MAN_MSB:0];                 // R23
        expo   = w[L11_EXP_MSB:L11_EXP_LSB];
        prod   = 48'(man) * 48'(US_PER_MS);
        scaled = '0;
        if (man > 0) begin
            if (expo >= 0)
                scaled = prod << expo;
            else
                scaled = (prod + ((48'd1 << (-expo)) - 48'd1)) >> (-expo); // round up
        end
        if (man <= 0)
            l11_ms_to_us = '0;
        else if (scaled[47:32] != '0)
            l11_ms_to_us = '1;                     // saturate very long delays
        else
            l11_ms_to_us = scaled[31:0];
    endfunction

    // command decode: which table entry, and what kind of request
    always_comb begin
        hit_rw  = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < RW_COUNT; i++) begin
            if (req.code == RW_CODE[i]) begin
                hit_rw  = 1'b1;
                hit_idx = 5'(i);
            end
        end
    end

    assign is_write   = req_valid && req.write && !req.send;
    assign is_send    = req_valid && req.send;
    assign do_restore = is_send && req.code == CODE_RESTORE;               // R14
    // writes to read-only or unknown codes, and unknown send bytes, are refused
    assign bad_cmd    = (is_write && !hit_rw)                              // R26
                     || (is_send && req.code != CODE_RESTORE && req.code != CODE_AUTOTUNE_GO);

    // read/write settings; restore reloads every factory value
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < RW_COUNT; i++)
                rw_reg[i] <= RW_RESET[i];                                // R09
        end else if (do_restore) begin
            for (int i = 0; i < RW_COUNT; i++)
                rw_reg[i] <= RW_RESET[i];                                // R14
        end else if (is_write && hit_rw) begin
            if (RW_IS_BYTE[hit_idx])
                rw_reg[hit_idx] <= {8'h00, req.data[7:0]};
            else
                rw_reg[hit_idx] <= req.data;
        end
    end

    always_comb begin
        for (int i = 0; i < RW_COUNT; i++)
            config_words[i] = rw_reg[i];
    end

    // communication error flags: a new error wins over a clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            comm_err <= COMM_ERR_RESET;                                  // R01
        else begin
            if (fault_clear)
                comm_err <= COMM_ERR_RESET;
            if (bad_cmd)
                comm_err[COMM_ERR_BAD_CMD] <= 1'b1;                      // R26
        end
    end

    // vendor monitor flags are sticky until cleared, set wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            vendor_mon <= VENDOR_MON_RESET;                              // R02
        else
            vendor_mon <= (fault_clear ? VENDOR_MON_RESET : vendor_mon) | vendor_fault_set;
    end

    // capture record latched on request of the monitor logic
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            capture_rec <= '0;
        else if (capture_strobe)
            capture_rec <= capture_data;                                 // R13
    end

    // command pulses for the compensation engine and restore handshake
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            autotune_start <= 1'b0;
            restore_done   <= 1'b0;
        end else begin
            autotune_start <= is_send && req.code == CODE_AUTOTUNE_GO;   // R08
            restore_done   <= do_restore;
        end
    end

    // read multiplexer; block reads return one byte per request
    always_comb begin
        next_rsp_data = 16'h0000;
        next_rsp_err  = bad_cmd;
        if (req_valid && !req.write && !req.send) begin
            case (req.code)
                CODE_COMM_ERR:   next_rsp_data = {8'h00, comm_err};      // R01
                CODE_VENDOR_MON: next_rsp_data = {8'h00, vendor_mon};    // R02
                CODE_VIN:        next_rsp_data = telemetry.vin;          // R03
                CODE_VOUT:       next_rsp_data = telemetry.vout;         // R04
                CODE_IOUT:       next_rsp_data = telemetry.iout;         // R05
                CODE_TEMP_INT:   next_rsp_data = telemetry.temp_int;     // R06
                CODE_TEMP_EXT:   next_rsp_data = telemetry.temp_ext;     // R06
                CODE_DUTY:       next_rsp_data = telemetry.duty;         // R07
                CODE_FREQ:       next_rsp_data = telemetry.freq;         // R07
                CODE_BUS_REV:    next_rsp_data = {8'h00, BUS_REV_VALUE};
                CODE_CAPTURE:
                    next_rsp_data = {8'h00, capture_rec[8*req.byte_idx +: 8]}; // R13
                CODE_SAVED_IND: begin
                    if (req.byte_idx < 5'(SAVED_IND_BYTES))
                        next_rsp_data = {8'h00, SAVED_IND_RESET[8*req.byte_idx[0] +: 8]}; // R22
                end
                default: begin
                    if (hit_rw)
                        next_rsp_data = rw_reg[hit_idx];
                    else
                        next_rsp_err = 1'b1;
                end
            endcase
        end
    end

    // answer one cycle after every request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 16'h0000;
            rsp_err   <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
            rsp_err   <= req_valid && next_rsp_err;
            if (req_valid)
                rsp_data <= next_rsp_data;
        end
    end

    // threshold comparator is asynchronous to mclk
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            thr_meta <= 1'b0;
            thr_sync <= 1'b0;
        end else begin
            thr_meta <= good_threshold_raw;
            thr_sync <= thr_meta;
        end
    end

    // microsecond tick keeps the delay counter narrow
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick <= tick_cnt == 5'(TICK_CYCLES - 1);
            if (tick_cnt == 5'(TICK_CYCLES - 1))
                tick_cnt <= '0;
            else
                tick_cnt <= tick_cnt + 5'd1;
        end
    end

    assign good_delay_us = l11_ms_to_us(rw_reg[IDX_GOOD_DELAY]);

    // good pin: counts whole microseconds with threshold met, drops at once
    // when it is lost; delay resolution is one tick, a trade for width
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            good_cnt        <= '0;
            output_good_pin <= 1'b0;
        end else if (!thr_sync) begin
            good_cnt        <= '0;
            output_good_pin <= 1'b0;                                     // R12
        end else begin
            if (tick && good_cnt != '1)
                good_cnt <= good_cnt + 32'd1;
            // first tick is partial, so one extra whole tick keeps the pin from rising early
            output_good_pin <= (good_delay_us == '0) || (good_cnt > good_delay_us); // R12
        end
    end

    // checks
    restore_reload_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
        do_restore |=> rw_reg[IDX_AUTOTUNE_CFG] == 16'h0069 && rw_reg[IDX_SWITCH_GAP] == 16'h1014)
        else $error("factory restore did not reload defaults");

    ro_write_flag_a: assert property (@(posedge mclk) disable iff (!reset_n) // R26
        (is_write && req.code == CODE_VIN) |=> comm_err[COMM_ERR_BAD_CMD] && rsp_err)
        else $error("write to read-only code not flagged");

    autotune_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n) // R08
        (is_send && req.code == CODE_AUTOTUNE_GO) |=> autotune_start ##1 (!autotune_start
            || ($past(is_send) && $past(req.code) == CODE_AUTOTUNE_GO)))
        else $error("autotune start pulse wrong");

    vin_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R03
        (req_valid && !req.write && !req.send && req.code == CODE_VIN)
            |=> rsp_valid && rsp_data == $past(telemetry.vin))
        else $error("input voltage read wrong");

    vout_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R04
        (req_valid && !req.write && !req.send && req.code == CODE_VOUT)
            |=> rsp_data == $past(telemetry.vout))
        else $error("output voltage read wrong");

    good_drop_a: assert property (@(posedge mclk) disable iff (!reset_n) // R12
        !thr_sync |=> !output_good_pin)
        else $error("good pin held without threshold");

    good_wait_a: assert property (@(posedge mclk) disable iff (!reset_n) // R12
        $rose(thr_sync) && rw_reg[IDX_GOOD_DELAY] == 16'hba00
            |-> !output_good_pin [*8])
        else $error("good pin rose before delay");

    saved_ind_a: assert property (@(posedge mclk) disable iff (!reset_n) // R22
        (req_valid && !req.write && !req.send && req.code == CODE_SAVED_IND
            && req.byte_idx == 5'd0) |=> rsp_data == 16'h00ff)
        else $error("saved indicator read wrong");

    capture_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
        (req_valid && !req.write && !req.send && req.code == CODE_CAPTURE
            && req.byte_idx == 5'd0) |=> rsp_data[7:0] == $past(capture_rec[7:0]))
        else $error("capture record read wrong");

    err_clear_a: assert property (@(posedge mclk) disable iff (!reset_n) // R01
        (fault_clear && !bad_cmd) |=> comm_err == 8'h00)
        else $error("error flags not cleared");

    vendor_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n) // R02
        vendor_fault_set != 8'h00
            |=> (vendor_mon & $past(vendor_fault_set)) == $past(vendor_fault_set))
        else $error("vendor flag lost");

    restore_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
        do_restore |=> restore_done && config_words[IDX_GOOD_DELAY] == 16'hba00)
        else $error("restore pulse or delay default wrong");

    byte_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // R09
        (is_write && req.code == 8'hbc) |=> rw_reg[IDX_AUTOTUNE_CFG][15:8] == 8'h00)
        else $error("byte register kept upper byte");

    capture_ro_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
        (is_write && req.code == CODE_CAPTURE) |=> rsp_err && comm_err[COMM_ERR_BAD_CMD])
        else $error("capture write not refused");

    send_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n) // R26
        (is_send && req.code != CODE_RESTORE && req.code != CODE_AUTOTUNE_GO)
            |=> rsp_err && comm_err[COMM_ERR_BAD_CMD])
        else $error("unknown send byte not refused");

    iout_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R05
        (req_valid && !req.write && !req.send && req.code == CODE_IOUT)
            |=> rsp_data == $past(telemetry.iout))
        else $error("output current read wrong");

    temp_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R06
        (req_valid && !req.write && !req.send && req.code == CODE_TEMP_EXT)
            |=> rsp_data == $past(telemetry.temp_ext))
        else $error("external temperature read wrong");

    duty_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R07
        (req_valid && !req.write && !req.send && req.code == CODE_DUTY)
            |=> rsp_data == $past(telemetry.duty))
        else $error("duty cycle read wrong");

endmodule // power_module_command_bank

// ### src/cmd_bank_pkg.sv
// Constants, field layouts and carrier types for the power module command bank.
// Assumes a single 25 MHz register clock; the serial bus engine sits outside.
//
// Function
// R01: read-only communication/logic error byte at 7Eh, clear value 00h.
// R02: read-only vendor monitor status byte at 80h, starts at zero.
// R03: word 88h returns input voltage in eleven-bit linear form.
// R04: word 8Bh returns output voltage in unsigned sixteen-bit linear form.
// R05: word 8Ch returns output current in eleven-bit linear form.
// R06: words 8Dh/8Eh return internal and external temperature, eleven-bit linear.
// R07: words 94h/95h return duty cycle and switching frequency, eleven-bit linear.
// R08: send-byte BDh starts the automatic loop compensation.
// R09: autotune config byte BCh resets to 69h.
// R10: maximum dead-time word BFh resets to 3838h.
// R11: dead-time word DDh resets to 1014h.
// R12: good pin waits the D4h delay (reset BA00h, 1 ms) after threshold.
// R13: block read EAh returns a 32-byte captured record, read-only.
// R14: send-byte F4h reloads every setting with its factory default.
// R15: phase shed control byte resets to 00h.
// R16: output fault detect byte D8h resets to zero.
// R17: over/undercurrent response bytes E5h/E6h reset to 80h.
// R18: average current limits reset to D249h and D5B7h.
// R19: extra options word E9h resets to 2000h.
// R20: load share word D2h resets to 0000h.
// R21: follow mode byte E1h resets to zero.
// R22: read-only block EBh shows recently saved parameters, reset FFFFh.
// R23: eleven-bit linear packs 5-bit exponent over 11-bit mantissa.
// R24: unsigned sixteen-bit linear is a 16-bit mantissa times 2^-13.
// R25: host leaves at least 2 ms between repeated reads; host_model does not keep this spacing.
// R26: writes to read-only codes are ignored and flagged as communication error.
package cmd_bank_pkg;

    // timing
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned TICK_NS     = 1000;
    localparam int unsigned TICK_CYCLES = TICK_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned US_PER_MS   = 1000;

    // read-only command codes
    localparam logic [7:0] CODE_COMM_ERR   = 8'h7e; // R01
    localparam logic [7:0] CODE_VENDOR_MON = 8'h80; // R02
    localparam logic [7:0] CODE_VIN        = 8'h88;
    localparam logic [7:0] CODE_VOUT       = 8'h8b;
    localparam logic [7:0] CODE_IOUT       = 8'h8c;
    localparam logic [7:0] CODE_TEMP_INT   = 8'h8d;
    localparam logic [7:0] CODE_TEMP_EXT   = 8'h8e;
    localparam logic [7:0] CODE_DUTY       = 8'h94;
    localparam logic [7:0] CODE_FREQ       = 8'h95;
    localparam logic [7:0] CODE_BUS_REV    = 8'h98;
    localparam logic [7:0] CODE_CAPTURE    = 8'hea;
    localparam logic [7:0] CODE_SAVED_IND  = 8'heb;
    // send-byte command codes
    localparam logic [7:0] CODE_AUTOTUNE_GO = 8'hbd;
    localparam logic [7:0] CODE_RESTORE     = 8'hf4;

    // status layout and fixed values
    localparam logic [7:0]  COMM_ERR_RESET   = 8'h00;
    localparam int unsigned COMM_ERR_BAD_CMD = 7;
    localparam logic [7:0]  VENDOR_MON_RESET = 8'h00;
    localparam logic [15:0] SAVED_IND_RESET  = 16'hffff; // R22
    localparam int unsigned CAPTURE_BYTES    = 32;        // R13
    localparam int unsigned SAVED_IND_BYTES  = 2;
    localparam logic [7:0]  BUS_REV_VALUE    = 8'h11;     // arbitrary value

    // linear format fields
    localparam int unsigned L11_EXP_MSB = 15; // R23
    localparam int unsigned L11_EXP_LSB = 11;
    localparam int unsigned L11_MAN_MSB = 10;
    localparam int unsigned LINEAR_SIXTEEN_UNSIGNED_FORMAT_EXP    = 13; // R24

    // read/write register table: code, reset, byte or word
    localparam int unsigned RW_COUNT = 23;
    localparam logic [7:0] RW_CODE [RW_COUNT] = '{
        8'hbc, 8'hbf, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdc,
        8'hdd, 8'hde, 8'he0, 8'he1, 8'he5, 8'he6, 8'he7, 8'he8, 8'he9, 8'hf0, 8'hf3};
    localparam logic [15:0] RW_RESET [RW_COUNT] = '{
        16'h0069, // autotune config R09
        16'h3838, // max switch gap R10
        16'h6a11, // vendor feature config
        16'h2011, // user feature config
        16'h0000, // load share config R20
        16'h0001, // rail link config
        16'hba00, // good assert delay R12
        16'hba00, // inductance
        16'h0000, // output fault detect R16
        16'hba00, // remote temp scale
        16'h8000, // remote temp offset
        16'h0028, // temp coefficient
        16'h1014, // switch gap setting R11
        16'h8686, // adaptive gap
        16'h0000, // rail order
        16'h0000, // follow mode R21
        16'h0080, // overcurrent response R17
        16'h0080, // undercurrent response R17
        16'hd249, // avg overcurrent limit R18
        16'hd5b7, // avg undercurrent limit R18
        16'h2000, // extra options R19
        16'h0000, // phase shed control R15
        16'h0000};// capture handling control
    localparam logic RW_IS_BYTE [RW_COUNT] = '{
        1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
        1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam int unsigned IDX_AUTOTUNE_CFG = 0;
    localparam int unsigned IDX_SWITCH_GAP   = 12;
    localparam int unsigned IDX_GOOD_DELAY   = 6;

    // one command from the bus engine
    typedef struct packed {
        logic [7:0]  code;
        logic        write;     // write byte/word
        logic        send;      // data-less send byte
        logic [15:0] data;
        logic [4:0]  byte_idx;  // byte number within a block read
    } cmd_req_s;

    // telemetry words from the measurement logic
    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp_int;
        logic [15:0] temp_ext;
        logic [15:0] duty;
        logic [15:0] freq;
    } telemetry_s;

endpackage

// ### sim/host_model.sv
// Host-side model: issues one command request at a time to the command bank.
// Assumes the bank answers on the same edge that takes a request.
`timescale 1ns/100ps

module host_model
    import cmd_bank_pkg::*;
(
    input  wire logic        mclk,
    output logic             req_valid,
    output cmd_req_s         req,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rsp_err
);
    // idle bus before the first request
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // one transfer; released fields flip so stale values never pass for live ones
    // read spacing is the host's to keep; skipped here to keep the run short
    task automatic xfer(input logic [7:0] code, input logic wr, input logic snd,
                        input logic [15:0] data, input logic [4:0] idx,
                        output logic [15:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        req_valid <= 1'b1;
        req       <= '{code: code, write: wr, send: snd, data: data, byte_idx: idx};
        @(posedge mclk);
        req_valid <= 1'b0;
        req       <= ~req;
        #1;
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        rd  = rsp_data;
        err = (rsp_valid === 1'b1) ? rsp_err : 1'bx;
    endtask
endmodule // host_model

// ### sim/testbench.sv
// Self-checking bench for the command bank: reads, writes, sends, power good.
// Assumes host_model drives the request port and a 25 MHz clock.
`timescale 1ns/100ps

module testbench import cmd_bank_pkg::*;;
    logic                       mclk, reset_n, req_valid, rsp_valid, rsp_err;
    logic                       fault_clear, capture_strobe, good_threshold_raw;
    logic                       output_good_pin, autotune_start, restore_done;
    cmd_req_s                   req;
    telemetry_s                 telemetry;
    logic [15:0]                rsp_data, rd;
    logic [7:0]                 vendor_fault_set;
    logic [8*CAPTURE_BYTES-1:0] capture_data;
    logic [RW_COUNT-1:0][15:0]  config_words;
    logic                       er;
    int                         bad_count, checks, tune_n, restore_n, n;
    logic [7:0]                 tcode [7] = '{CODE_VIN, CODE_VOUT, CODE_IOUT, CODE_TEMP_INT,
                                              CODE_TEMP_EXT, CODE_DUTY, CODE_FREQ};

    power_module_command_bank u_power_module_command_bank (
        .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
        .telemetry(telemetry), .vendor_fault_set(vendor_fault_set),
        .fault_clear(fault_clear), .capture_strobe(capture_strobe),
        .capture_data(capture_data), .good_threshold_raw(good_threshold_raw),
        .output_good_pin(output_good_pin), .autotune_start(autotune_start),
        .restore_done(restore_done), .config_words(config_words));

    host_model u_host_model (
        .mclk(mclk), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_err(rsp_err));

    // 40 ns clock
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // count one-cycle command pulses
    always @(posedge mclk) begin
        if (autotune_start === 1'b1) tune_n++;
        if (restore_done === 1'b1) restore_n++;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // read with expected data and error flag
    task automatic rdx(input logic [7:0] c, input logic [4:0] i, input logic [15:0] e,
                       input logic ee);
        u_host_model.xfer(c, 1'b0, 1'b0, 16'h0000, i, rd, er);
        chk16(rd, e);
        chk1(er, ee);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ee);
        u_host_model.xfer(c, 1'b1, 1'b0, d, 5'h00, rd, er);
        chk1(er, ee);
    endtask

    task automatic snd(input logic [7:0] c, input logic ee);
        u_host_model.xfer(c, 1'b0, 1'b1, 16'h0000, 5'h00, rd, er);
        chk1(er, ee);
    endtask

    // every r/w register at its table default, seen at ports and over the bus
    task automatic chk_defaults;
        for (int i = 0; i < RW_COUNT; i++) begin
            chk16(config_words[i], RW_RESET[i]);
            rdx(RW_CODE[i], 5'h00, RW_RESET[i], 1'b0);
        end
    endtask

    // one-cycle strobe: 0 pulses fault_clear, 1 pulses capture_strobe
    task automatic pulse(input logic sel);
        @(posedge mclk);
        if (sel)
            capture_strobe <= 1'b1;
        else
            fault_clear <= 1'b1;
        @(posedge mclk);
        capture_strobe <= 1'b0;
        fault_clear    <= 1'b0;
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // a full run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        end_of_test;
    end

    initial begin
        reset_n = 1'b0;
        fault_clear = 1'b0;
        capture_strobe = 1'b0;
        good_threshold_raw = 1'b0;
        vendor_fault_set = 8'h00;
        telemetry = {16'hd9a0, 16'h2666, 16'hdb00, 16'he320, 16'he348, 16'hf2d0, 16'h0a58};
        for (int i = 0; i < CAPTURE_BYTES; i++) capture_data[8*i +: 8] = 8'h40 + 8'(i);
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        chk_defaults;
        rdx(CODE_COMM_ERR, 5'h00, 16'h0000, 1'b0);
        rdx(CODE_VENDOR_MON, 5'h00, 16'h0000, 1'b0);
        for (int i = 0; i < 7; i++) rdx(tcode[i], 5'h00, telemetry[16*(6-i) +: 16], 1'b0);
        rdx(CODE_BUS_REV, 5'h00, {8'h00, BUS_REV_VALUE}, 1'b0);
        rdx(8'h90, 5'h00, 16'h0000, 1'b1);
        // byte register keeps the low byte only
        wr(8'hbc, 16'h1234, 1'b0);
        rdx(8'hbc, 5'h00, 16'h0034, 1'b0);
        // refused write to a telemetry code is flagged, then cleared
        wr(CODE_VIN, 16'h5555, 1'b1);
        rdx(CODE_COMM_ERR, 5'h00, 16'h0080, 1'b0);
        rdx(CODE_VIN, 5'h00, telemetry.vin, 1'b0);
        pulse(1'b0);
        rdx(CODE_COMM_ERR, 5'h00, 16'h0000, 1'b0);
        @(posedge mclk) vendor_fault_set <= 8'h05;
        @(posedge mclk) vendor_fault_set <= 8'h00;
        rdx(CODE_VENDOR_MON, 5'h00, 16'h0005, 1'b0);
        pulse(1'b0);
        rdx(CODE_VENDOR_MON, 5'h00, 16'h0000, 1'b0);
        snd(8'h90, 1'b1);
        snd(CODE_AUTOTUNE_GO, 1'b0);
        // capture record is byte-indexed and read-only
        pulse(1'b1);
        rdx(CODE_CAPTURE, 5'd0, 16'h0040, 1'b0);
        rdx(CODE_CAPTURE, 5'd31, 16'h005f, 1'b0);
        wr(CODE_CAPTURE, 16'h0001, 1'b1);
        rdx(CODE_SAVED_IND, 5'd0, 16'h00ff, 1'b0);
        rdx(CODE_SAVED_IND, 5'd1, 16'h00ff, 1'b0);
        rdx(CODE_SAVED_IND, 5'd2, 16'h0000, 1'b0);
        // short good delay: 2^-9 ms is 48.8 cycles; rounded up to 2 us plus a partial tick, pin may rise up to about 30 cycles late
        wr(8'hd4, 16'hb801, 1'b0);
        rdx(8'hd4, 5'h00, 16'hb801, 1'b0);
        @(posedge mclk) good_threshold_raw <= 1'b1;
        n = 0;
        while (output_good_pin !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk1(n >= 49 && n <= 90, 1'b1);
        @(posedge mclk) good_threshold_raw <= 1'b0;
        repeat (5) @(posedge mclk);
        chk1(output_good_pin, 1'b0);
        // restore brings every setting back
        snd(CODE_RESTORE, 1'b0);
        chk_defaults;
        // restored 1 ms delay keeps the pin low long after the threshold is met
        @(posedge mclk) good_threshold_raw <= 1'b1;
        repeat (100) @(posedge mclk);
        chk1(output_good_pin, 1'b0);
        @(posedge mclk) good_threshold_raw <= 1'b0;
        @(posedge mclk);
        chk16(16'(tune_n), 16'd1);
        chk16(16'(restore_n), 16'd1);
        end_of_test;
    end
endmodule // testbench
